/* File: logic/adc_status_defines.vh */
`ifndef ADC_STATUS_DEFINES_VH
`define ADC_STATUS_DEFINES_VH

// register byte addresses
`define FMT_CTRL_ADDR 12'h000
`define RDY_LOW_ADDR 12'h004
`define RDY_HIGH_ADDR 12'h008
`define RESULT_BASE_ADDR 12'h100
`define IRQ_STATUS_ADDR 12'h010
`define IRQ_MASK_ADDR 12'h014

// field positions in the format control register
`define FORMAT_BIT 7
`define RES_LSB 5
`define RES_MSB 6

// format control reset value: integer format, 12-bit resolution
`define FMT_CTRL_RESET 3'b011

// resolution codes
`define RES_6BIT 2'b00
`define RES_8BIT 2'b01
`define RES_10BIT 2'b10
`define RES_12BIT 2'b11

// interrupt status bit positions
`define IRQ_READY_BIT 0
`define IRQ_OVERRUN_BIT 1

`endif

/* File: logic/adc_format_status.v */
// How it works
// - format bit one gives fractional results
// - two-bit code picks 12/10/8/6-bit resolution
// - low status holds ready flags 0-15
// - high status flags 16-20, rest zero
// - flag sets when result lands
// - flag zero until result; zero after reset
`include "adc_status_defines.vh"

module adc_format_status #(
    parameter NUM_CH = 21,
    parameter RAW_W = 12
)
(
    input wire MCLK,
    input wire RST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output wire PREADY,
    output reg [31:0] PRDATA,
    output wire PSLVERR,
    input wire [NUM_CH-1:0] CONV_DONE,
    input wire [NUM_CH*RAW_W-1:0] CONV_DATA,
    output wire FRACTIONAL_MODE,
    output wire [1:0] CORE_RESOLUTION,
    output wire IRQ
);

    reg output_format_select;
    reg [1:0] shared_core_resolution;
    reg [NUM_CH-1:0] ready_flags;
    reg [15:0] result_mem [0:NUM_CH-1];
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg [31:0] next_rdata;
    reg addr_ok;
    integer i;

    wire wr_en = PSEL & PENABLE & PWRITE;
    wire rd_en = PSEL & PENABLE & ~PWRITE;
    wire [11:0] rel_addr = PADDR - `RESULT_BASE_ADDR;
    wire [9:0] rel_index = rel_addr[11:2];
    wire in_results = (PADDR >= `RESULT_BASE_ADDR) && (rel_index < NUM_CH) && (PADDR[1:0] == 2'b00);
    wire [NUM_CH-1:0] read_clear;
    wire [NUM_CH*16-1:0] shaped_all;
    wire [15:0] ready_flags_low;
    wire [4:0] ready_flags_high;

    // zero wait states: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;
    assign FRACTIONAL_MODE = output_format_select;
    assign CORE_RESOLUTION = shared_core_resolution;
    assign ready_flags_low = ready_flags[15:0];
    assign ready_flags_high = ready_flags[20:16];
    assign IRQ = |(irq_status & irq_mask);

    always @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            {output_format_select, shared_core_resolution} <= `FMT_CTRL_RESET;
            irq_mask <= 2'b00;
        end
        else if (wr_en && PADDR == `FMT_CTRL_ADDR)
        begin
            output_format_select <= PWDATA[`FORMAT_BIT];
            shared_core_resolution <= PWDATA[`RES_MSB:`RES_LSB];
        end
        else if (wr_en && PADDR == `IRQ_MASK_ADDR)
        begin
            irq_mask <= PWDATA[1:0];
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1)
        begin : g_chan
            wire [RAW_W-1:0] raw = CONV_DATA[ch*RAW_W +: RAW_W];
            reg [15:0] shaped;
            // results are left-aligned in fractional mode, right-aligned by resolution in integer mode
            always @*
            begin
                shaped = 16'h0000;
                if (output_format_select)
                begin
                    case (shared_core_resolution)
                        `RES_12BIT: shaped = {raw[11:0], 4'h0};
                        `RES_10BIT: shaped = {raw[11:2], 6'h00};
                        `RES_8BIT: shaped = {raw[11:4], 8'h00};
                        default: shaped = {raw[11:6], 10'h000};
                    endcase
                end
                else
                begin
                    case (shared_core_resolution)
                        `RES_12BIT: shaped = {4'h0, raw[11:0]};
                        `RES_10BIT: shaped = {6'h00, raw[11:2]};
                        `RES_8BIT: shaped = {8'h00, raw[11:4]};
                        default: shaped = {10'h000, raw[11:6]};
                    endcase
                end
            end
            assign read_clear[ch] = rd_en && in_results && (rel_index == ch);
            assign shaped_all[ch*16 +: 16] = shaped;
        end
    endgenerate

    // one process owns all ready flags and result buffers, so every bit has a single driver
    always @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ready_flags <= {NUM_CH{1'b0}};
            for (i = 0; i < NUM_CH; i = i + 1)
            begin
                result_mem[i] <= 16'h0000;
            end
        end
        else
        begin
            for (i = 0; i < NUM_CH; i = i + 1)
            begin
                if (CONV_DONE[i])
                begin
                    // a new result wins over a read in the same cycle
                    ready_flags[i] <= 1'b1;
                    result_mem[i] <= shaped_all[i*16 +: 16];
                end
                else if (read_clear[i])
                begin
                    ready_flags[i] <= 1'b0;
                end
            end
        end
    end

    // events: any result arrives; a result lands on a channel still flagged ready and not being read that cycle
    wire ev_ready = |CONV_DONE;
    wire ev_overrun = |(CONV_DONE & ready_flags & ~read_clear);

    always @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_status <= 2'b00;
        end
        else
        begin
            // set has priority over write-one-to-clear
            if (wr_en && PADDR == `IRQ_STATUS_ADDR)
            begin
                irq_status <= (irq_status & ~PWDATA[1:0]) | {ev_overrun, ev_ready};
            end
            else
            begin
                irq_status <= irq_status | {ev_overrun, ev_ready};
            end
        end
    end

    always @*
    begin
        next_rdata = 32'h0000_0000;
        addr_ok = 1'b1;
        if (PADDR == `FMT_CTRL_ADDR)
        begin
            next_rdata[`FORMAT_BIT] = output_format_select;
            next_rdata[`RES_MSB:`RES_LSB] = shared_core_resolution;
        end
        else if (PADDR == `RDY_LOW_ADDR)
        begin
            next_rdata[15:0] = ready_flags_low;
        end
        else if (PADDR == `RDY_HIGH_ADDR)
        begin
            next_rdata[4:0] = ready_flags_high;
        end
        else if (PADDR == `IRQ_STATUS_ADDR)
        begin
            next_rdata[1:0] = irq_status;
        end
        else if (PADDR == `IRQ_MASK_ADDR)
        begin
            next_rdata[1:0] = irq_mask;
        end
        else if (in_results)
        begin
            next_rdata[15:0] = result_mem[rel_index[4:0]];
        end
        else
        begin
            addr_ok = 1'b0;
        end
    end

    // read data registered during setup so it is valid in the access cycle
    always @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PRDATA <= 32'h0000_0000;
        end
        else if (PSEL && !PENABLE && !PWRITE)
        begin
            PRDATA <= next_rdata;
        end
    end

endmodule

/* File: sim/adc_format_status_chk.sv */
module adc_format_status_chk #(parameter NUM_CH = 21)
(
    input wire MCLK,
    input wire RST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire [NUM_CH-1:0] CONV_DONE,
    input wire FRACTIONAL_MODE,
    input wire [1:0] CORE_RESOLUTION
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen;
    wire wr = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
    wire rs = PSEL && !PENABLE && !PWRITE;
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    // any result since reset; until then no flag 0-15 may read back as set
    always_ff @(posedge MCLK or negedge RST_N)
        if (!RST_N)
            seen <= 1'b0;
        else if (|CONV_DONE)
            seen <= 1'b1;
    chk_fmt_write: assert property (wr |=> FRACTIONAL_MODE == $past(PWDATA[7]))
        else $error("format bit");
    chk_res_write: assert property (wr |=> CORE_RESOLUTION == $past(PWDATA[6:5]))
        else $error("resolution");
    chk_low_flag: assert property (CONV_DONE[15] ##[1:4] (rs && PADDR == 12'h004) |=> PRDATA[15])
        else $error("low flag");
    chk_high_zero: assert property (rs && PADDR == 12'h008 |=> PRDATA[31:5] == 27'h000_0000)
        else $error("high bits");
    chk_ready_set: assert property (CONV_DONE[20] ##[1:8] (rs && PADDR == 12'h008) |=> PRDATA[4])
        else $error("flag set");
    chk_idle_zero: assert property (!seen && rs && PADDR == 12'h004 |=> PRDATA == 32'h0000_0000)
        else $error("flag idle");
    chk_read_clear: assert property ((PSEL && PENABLE && !PWRITE && PADDR == 12'h100) ##0 !CONV_DONE[0] [*3]
        ##0 (rs && PADDR == 12'h004) |=> !PRDATA[0])
        else $error("flag clear");
endmodule

bind adc_format_status adc_format_status_chk #(.NUM_CH(NUM_CH)) u_chk (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .CONV_DONE(CONV_DONE),
    .FRACTIONAL_MODE(FRACTIONAL_MODE), .CORE_RESOLUTION(CORE_RESOLUTION));

/* File: sim/adc_format_and_ready_status_bench.sv */
module adc_format_and_ready_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic [20:0] done = 21'h00_0000;
    logic [251:0] data = {240'h0, 12'hABC};
    // row: written byte, then the byte that should read back
    logic [15:0] rows [4] = '{16'hFFE0, 16'h8080, 16'h4040, 16'h2020};
    wire ready, err, fmt, irq;
    wire [1:0] res;
    wire [31:0] prdata;
    int n_fail = 0, n_tests = 0, k;
    adc_format_status u_dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(ready), .PRDATA(prdata), .PSLVERR(err), .CONV_DONE(done),
        .CONV_DATA(data), .FRACTIONAL_MODE(fmt), .CORE_RESOLUTION(res), .IRQ(irq));
    initial forever #5 mclk = ~mclk;
    task summarize;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x)
        begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (k = 0; k < 9; k++)
        begin
            @(posedge mclk);
            if (ready === 1'b1)
                break;
        end
        if (k == 9)
        begin
            n_fail++;
            summarize();
        end
        rd = prdata;
        e = err;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge mclk);
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        chk({irq, fmt, res}, 32'h0000_0003);
        rst_n <= 1'b1;
        apb(1'b0, 12'h004, 32'h0000_0000); chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000); chk(rd, 32'h0000_0060);
        $display("reset test done");
        @(posedge mclk);
        done <= 21'h11_8001;
        @(posedge mclk);
        done <= 21'h00_0000;
        apb(1'b0, 12'h004, 32'h0000_0000); chk(rd, 32'h0000_8001);
        apb(1'b0, 12'h008, 32'h0000_0000); chk(rd, 32'h0000_0011);
        apb(1'b0, 12'h100, 32'h0000_0000); chk(rd, 32'h0000_0ABC);
        apb(1'b0, 12'h004, 32'h0000_0000); chk(rd, 32'h0000_8000);
        chk(irq, 32'h0000_0000);
        apb(1'b1, 12'h014, 32'h0000_0001); chk(irq, 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_0001); chk(irq, 32'h0000_0000);
        apb(1'b0, 12'hFFC, 32'h0000_0000); chk({e, rd[30:0]}, 32'h8000_0000);
        $display("flag test done");
        foreach (rows[i])
        begin
            apb(1'b1, 12'h000, {24'h00_0000, rows[i][15:8]});
            apb(1'b0, 12'h000, 32'h0000_0000);
            chk(rd, {24'h00_0000, rows[i][7:0]});
            chk({fmt, res}, rows[i][7:5]);
        end
        $display("format test done");
        @(posedge mclk);
        done <= 21'h10_0001;
        data <= {12'h123, 228'h0, 12'hABC};
        @(posedge mclk);
        done <= 21'h00_0000;
        apb(1'b0, 12'h100, 32'h0000_0000); chk(rd, 32'h0000_00AB);
        apb(1'b0, 12'h150, 32'h0000_0000); chk(rd, 32'h0000_0012);
        apb(1'b1, 12'h000, 32'h0000_00E0);
        @(posedge mclk);
        done <= 21'h00_0001;
        @(posedge mclk);
        done <= 21'h00_0000;
        apb(1'b0, 12'h100, 32'h0000_0000); chk(rd, 32'h0000_ABC0);
        $display("shaping test done");
        @(posedge mclk);
        done <= 21'h00_0002;
        @(posedge mclk);
        done <= 21'h00_0000;
        @(posedge mclk);
        done <= 21'h00_0002;
        @(posedge mclk);
        done <= 21'h00_0000;
        apb(1'b0, 12'h010, 32'h0000_0000); chk(rd, 32'h0000_0003);
        @(posedge mclk);
        rst_n <= 1'b0;
        @(posedge mclk);
        chk({irq, fmt, res}, 32'h0000_0003);
        rst_n <= 1'b1;
        apb(1'b0, 12'h004, 32'h0000_0000); chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000); chk(rd, 32'h0000_0060);
        $display("overrun and mid-run reset test done");
        summarize();
    end
endmodule
